// ---- logic/nku_pkg.sv ----
package nku_pkg;
   // Device register map on the shared link
   localparam logic [15:0] REG_CR1 = 16'h0000;
   localparam logic [15:0] REG_CR2 = 16'h0001;
   localparam logic [15:0] REG_NCR2 = 16'h0002;
   localparam logic [15:0] REG_PKEY = 16'h0003;
   localparam logic [15:0] REG_DKEY = 16'h0004;
   localparam logic [15:0] REG_STAT = 16'h0005;
   localparam logic [15:0] DATA_BASE = 16'h0100;
   localparam logic [15:0] OPT_BASE = 16'h0200;
   localparam logic [15:0] PROG_BASE = 16'h1000;
   localparam logic [7:0] PKEY_FIRST = 8'h56;
   localparam logic [7:0] PKEY_SECOND = 8'hAE;
   localparam logic [7:0] DKEY_FIRST = 8'hAE;
   localparam logic [7:0] DKEY_SECOND = 8'h56;
   localparam logic [7:0] ROP_ON = 8'hAA;
   localparam logic [7:0] ERASED = 8'h00;
   localparam logic [7:0] CR2_RST = 8'h00;
   localparam logic [7:0] NCR2_RST = 8'hFF;
   localparam int CR1_IE_BIT = 0;
   localparam int CR2_OPT_BIT = 7;
   localparam int ST_WPD_BIT = 0;
   localparam int ST_PUL_BIT = 1;
   localparam int ST_EOP_BIT = 2;
   localparam int ST_DUL_BIT = 3;
   localparam int ROP_IDX = 0;
   localparam int UBC_IDX = 1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_PROG_NS = 6000;
   localparam int PROG_CYC = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {KEY_IDLE = 2'b00, KEY_ONE = 2'b01, KEY_OPEN = 2'b11, KEY_LOCK = 2'b10} nku_key_t;
   // Host-side AHB register map
   localparam logic [1:0] HREG_CMD = 2'h0;
   localparam logic [1:0] HREG_STAT = 2'h1;
   localparam logic [1:0] HREG_CTRL = 2'h2;
   localparam int CMD_DATA_LSB = 16;
   localparam int CMD_KIND_LSB = 24;
   localparam int CMD_PORT_BIT = 26;
   localparam int HS_BUSY_BIT = 0;
   localparam int HS_DONE_BIT = 1;
   localparam int HS_REF_BIT = 2;
   localparam int HS_IRQ_BIT = 3;
   localparam int HS_RD_LSB = 8;
   typedef enum logic [1:0] {K_READ = 2'b00, K_WRITE = 2'b01, K_CHECKED = 2'b10} nku_kind_t;
   typedef enum logic [2:0] {H_IDLE = 3'b000, H_CHK_ST = 3'b001, H_CHK_C2 = 3'b011, H_CHK_N2 = 3'b010,
      H_XFER = 3'b110} nku_hst_t;
endpackage

// ---- logic/nku_if.sv ----
`timescale 1ns/1ps
interface nku_if;
   logic cpu_req;
   logic cpu_we;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata;
   logic [7:0] cpu_rdata;
   logic cpu_ready;
   logic dbg_req;
   logic dbg_we;
   logic [15:0] dbg_addr;
   logic [7:0] dbg_wdata;
   logic [7:0] dbg_rdata;
   logic dbg_ready;
   logic dbg_refused;
   logic dbg_halt;
   logic dbg_run;
   logic cpu_halt;
   logic irq;
   modport dev
   (
      input cpu_req, cpu_we, cpu_addr, cpu_wdata, dbg_req, dbg_we, dbg_addr, dbg_wdata, dbg_halt, dbg_run,
      output cpu_rdata, cpu_ready, dbg_rdata, dbg_ready, dbg_refused, cpu_halt, irq
   );
   modport host
   (
      output cpu_req, cpu_we, cpu_addr, cpu_wdata, dbg_req, dbg_we, dbg_addr, dbg_wdata, dbg_halt, dbg_run,
      input cpu_rdata, cpu_ready, dbg_rdata, dbg_ready, dbg_refused, cpu_halt, irq
   );
endinterface

// ---- logic/nku_dev.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Data region write locked after reset
// - Option writes need enable set, complement clear
// - Readout protect blocks debug program and data access
// - Protected part: debug cannot release CPU
// - Debug rewrite of protect byte erases all
// - Both regions start locked after reset
// - Boot area pages always write protected
// - First program key compared with 0x56
// - Wrong first program key locks key register
// - Second program key 0xAE, mismatch locks
// - Both program keys unlock, set flag
// - Check program flag; clearing relocks program memory
// - First data key 0xAE, mismatch retries
// - Second data key 0x56, mismatch locks
// - Data keys unlock, flag checked, clear relocks
// - Option writes need data keys plus enable
// - Data writes overlap program reads, not reverse
// - Control register access while busy stalls
// - Store starts byte program; program stalls CPU
// - Storing 0x00 erases the byte
// - Done flag on success, violation flag otherwise
// - Flags raise interrupt when enabled
module nku_dev
#(
   parameter int PROG_BYTES = 256,
   parameter int DATA_BYTES = 64,
   parameter int OPT_BYTES = 8,
   parameter int PAGE_BYTES = 16,
   parameter bit RWW_CAP = 1'b1,
   parameter bit MED_HIGH = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   nku_if.dev bus
);
   localparam int PW = $clog2(PROG_BYTES);
   localparam int DW = $clog2(DATA_BYTES);
   localparam int OW = $clog2(OPT_BYTES);
   localparam int PGW = $clog2(PAGE_BYTES);
   localparam int CW = $clog2(nku_pkg::PROG_CYC + 1);

   if (PROG_BYTES != (1 << PW) || DATA_BYTES != (1 << DW) || OPT_BYTES != (1 << OW) || OPT_BYTES < 2
      || PAGE_BYTES != (1 << PGW) || PAGE_BYTES > PROG_BYTES || PROG_BYTES > 4096)
   begin : g_bad_size
      $error("nku_dev: region sizes must be powers of two within the map");
   end

   typedef struct packed {
      nku_pkg::nku_key_t pk;
      nku_pkg::nku_key_t dk;
      logic pul;
      logic data_unlock_flag;
      logic ie;
      logic [7:0] cr2;
      logic [7:0] ncr2;
      logic eop;
      logic wpd;
      logic busy;
      logic bprog;
      logic [CW-1:0] cnt;
      logic [15:0] taddr;
      logic [7:0] tdata;
      logic [7:0] rdata;
      logic [7:0] drdata;
      logic dref;
      logic halt;
      logic irq;
      logic [PROG_BYTES-1:0][7:0] prog;
      logic [DATA_BYTES-1:0][7:0] data;
      logic [OPT_BYTES-1:0][7:0] option_write_enable;
   } nku_dev_st_t;

   nku_dev_st_t s_r;
   nku_dev_st_t s_nxt;

   function automatic logic in_rg(input logic [15:0] a, input logic [15:0] b, input int n);
      return ({16'h0000, a} >= {16'h0000, b}) && ({16'h0000, a} < ({16'h0000, b} + 32'(n)));
   endfunction

   function automatic logic rop_on(input nku_dev_st_t s);
      return s.option_write_enable[nku_pkg::ROP_IDX] == nku_pkg::ROP_ON;
   endfunction

   // One engine: memory and CR1/CR2 wait while it runs, except program reads during data work
   function automatic logic stalled(input nku_dev_st_t s, input logic [15:0] a, input logic we);
      logic isp;
      logic ism;
      logic cr;
      isp = in_rg(a, nku_pkg::PROG_BASE, PROG_BYTES);
      ism = isp || in_rg(a, nku_pkg::DATA_BASE, DATA_BYTES) || in_rg(a, nku_pkg::OPT_BASE, OPT_BYTES);
      cr = (a == nku_pkg::REG_CR1) || (a == nku_pkg::REG_CR2);
      return s.busy && (s.bprog || !RWW_CAP || cr || (ism && !(isp && !we)));
   endfunction

   function automatic nku_dev_st_t acc(input nku_dev_st_t s, input logic dbg, input logic we,
      input logic [15:0] a, input logic [7:0] d);
      nku_dev_st_t n;
      logic [15:0] op;
      logic [15:0] od;
      logic [15:0] oo;
      logic isp;
      logic isd;
      logic iso;
      logic prot;
      logic [7:0] rv;
      n = s;
      op = a - nku_pkg::PROG_BASE;
      od = a - nku_pkg::DATA_BASE;
      oo = a - nku_pkg::OPT_BASE;
      isp = in_rg(a, nku_pkg::PROG_BASE, PROG_BYTES);
      isd = in_rg(a, nku_pkg::DATA_BASE, DATA_BYTES);
      iso = in_rg(a, nku_pkg::OPT_BASE, OPT_BYTES);
      rv = 8'h00;
      prot = 1'b0;
      if (dbg && rop_on(s) && (isp || isd))
      begin
         n.dref = 1'b1;
      end
      else if (we)
      begin
         if (a == nku_pkg::REG_CR1)
         begin
            n.ie = d[nku_pkg::CR1_IE_BIT];
         end
         else if (a == nku_pkg::REG_CR2)
         begin
            n.cr2 = d;
         end
         else if (a == nku_pkg::REG_NCR2)
         begin
            n.ncr2 = d;
         end
         else if (a == nku_pkg::REG_PKEY)
         begin
            // Keys are compared, never stored
            case (s.pk)
               nku_pkg::KEY_IDLE: n.pk = (d == nku_pkg::PKEY_FIRST) ? nku_pkg::KEY_ONE : nku_pkg::KEY_LOCK;
               nku_pkg::KEY_ONE:
               begin
                  n.pk = (d == nku_pkg::PKEY_SECOND) ? nku_pkg::KEY_OPEN : nku_pkg::KEY_LOCK;
                  n.pul = (d == nku_pkg::PKEY_SECOND);
               end
               default: n.pk = s.pk;
            endcase
         end
         else if (a == nku_pkg::REG_DKEY)
         begin
            case (s.dk)
               nku_pkg::KEY_IDLE: n.dk = (d == nku_pkg::DKEY_FIRST) ? nku_pkg::KEY_ONE : nku_pkg::KEY_IDLE;
               nku_pkg::KEY_ONE:
               begin
                  n.dk = (d == nku_pkg::DKEY_SECOND) ? nku_pkg::KEY_OPEN : nku_pkg::KEY_LOCK;
                  n.data_unlock_flag = (d == nku_pkg::DKEY_SECOND);
               end
               default: n.dk = s.dk;
            endcase
         end
         else if (a == nku_pkg::REG_STAT)
         begin
            // Flags can only be cleared; a fresh key pair may then reopen
            if (!d[nku_pkg::ST_PUL_BIT] && s.pul)
            begin
               n.pul = 1'b0;
               n.pk = nku_pkg::KEY_IDLE;
            end
            if (!d[nku_pkg::ST_DUL_BIT] && s.data_unlock_flag)
            begin
               n.data_unlock_flag = 1'b0;
               n.dk = nku_pkg::KEY_IDLE;
            end
         end
         else if (dbg && iso && oo[OW-1:0] == OW'(nku_pkg::ROP_IDX) && rop_on(s))
         begin
            n.prog = '0;
            n.data = '0;
            n.option_write_enable = '0;
            n.eop = 1'b1;
         end
         else if (isp || isd || iso)
         begin
            if (isp)
            begin
               prot = !s.pul || ((op >> PGW) < {8'h00, s.option_write_enable[nku_pkg::UBC_IDX]});
            end
            else if (isd)
            begin
               prot = !s.data_unlock_flag;
            end
            else
            begin
               prot = !(s.data_unlock_flag && s.cr2[nku_pkg::CR2_OPT_BIT] && !s.ncr2[nku_pkg::CR2_OPT_BIT]);
            end
            if (prot)
            begin
               n.wpd = 1'b1;
            end
            else
            begin
               n.busy = 1'b1;
               n.bprog = isp;
               n.cnt = CW'(nku_pkg::PROG_CYC - 1);
               n.taddr = a;
               n.tdata = d;
            end
         end
      end
      else
      begin
         if (a == nku_pkg::REG_CR1)
         begin
            rv[nku_pkg::CR1_IE_BIT] = s.ie;
         end
         else if (a == nku_pkg::REG_CR2)
         begin
            rv = s.cr2;
         end
         else if (a == nku_pkg::REG_NCR2)
         begin
            rv = s.ncr2;
         end
         else if (a == nku_pkg::REG_STAT)
         begin
            rv[nku_pkg::ST_WPD_BIT] = s.wpd;
            rv[nku_pkg::ST_PUL_BIT] = s.pul;
            rv[nku_pkg::ST_EOP_BIT] = s.eop;
            rv[nku_pkg::ST_DUL_BIT] = s.data_unlock_flag;
            n.eop = 1'b0;
            n.wpd = 1'b0;
         end
         else if (isp)
         begin
            rv = s.prog[op[PW-1:0]];
         end
         else if (isd)
         begin
            rv = s.data[od[DW-1:0]];
         end
         else if (iso)
         begin
            rv = s.option_write_enable[oo[OW-1:0]];
         end
         if (dbg)
         begin
            n.drdata = rv;
         end
         else
         begin
            n.rdata = rv;
         end
      end
      return n;
   endfunction

   logic cpu_ok;
   logic dbg_ok;
   logic [15:0] tp;
   logic [15:0] td;
   logic [15:0] to;

   assign cpu_ok = !stalled(s_r, bus.cpu_addr, bus.cpu_we);
   // CPU wins a same-cycle collision; the debug side simply waits
   assign dbg_ok = !bus.cpu_req && !stalled(s_r, bus.dbg_addr, bus.dbg_we);
   assign tp = s_r.taddr - nku_pkg::PROG_BASE;
   assign td = s_r.taddr - nku_pkg::DATA_BASE;
   assign to = s_r.taddr - nku_pkg::OPT_BASE;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.dref = 1'b0;
      if (bus.cpu_req && cpu_ok)
      begin
         s_nxt = acc(s_nxt, 1'b0, bus.cpu_we, bus.cpu_addr, bus.cpu_wdata);
      end
      else if (bus.dbg_req && dbg_ok)
      begin
         s_nxt = acc(s_nxt, 1'b1, bus.dbg_we, bus.dbg_addr, bus.dbg_wdata);
      end
      // Completion after the access so a set beats a same-cycle status read
      if (s_r.busy)
      begin
         if (s_r.cnt == '0)
         begin
            s_nxt.busy = 1'b0;
            s_nxt.bprog = 1'b0;
            s_nxt.eop = 1'b1;
            if (s_r.bprog)
            begin
               s_nxt.prog[tp[PW-1:0]] = s_r.tdata;
            end
            else if (in_rg(s_r.taddr, nku_pkg::DATA_BASE, DATA_BYTES))
            begin
               s_nxt.data[td[DW-1:0]] = s_r.tdata;
            end
            else
            begin
               s_nxt.option_write_enable[to[OW-1:0]] = s_r.tdata;
            end
         end
         else
         begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
      if (bus.dbg_halt)
      begin
         s_nxt.halt = 1'b1;
      end
      else if (bus.dbg_run && !(MED_HIGH && rop_on(s_r)))
      begin
         s_nxt.halt = 1'b0;
      end
      s_nxt.irq = s_nxt.ie && (s_nxt.eop || s_nxt.wpd);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.ncr2 <= nku_pkg::NCR2_RST;
         s_r.cr2 <= nku_pkg::CR2_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign bus.cpu_ready = cpu_ok;
   assign bus.dbg_ready = dbg_ok;
   assign bus.cpu_rdata = s_r.rdata;
   assign bus.dbg_rdata = s_r.drdata;
   assign bus.dbg_refused = s_r.dref;
   assign bus.cpu_halt = s_r.halt;
   assign bus.irq = s_r.irq;
endmodule

// ---- logic/nku_host.sv ----
`timescale 1ns/1ps
module nku_host
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   nku_if.host bus
);
   typedef struct packed {
      nku_pkg::nku_hst_t st;
      nku_pkg::nku_kind_t kind;
      logic port;
      logic [15:0] addr;
      logic [7:0] data;
      logic req;
      logic we;
      logic [15:0] aout;
      logic [7:0] dout;
      logic wt;
      logic done;
      logic refd;
      logic [7:0] rd;
      logic wph;
      logic [1:0] wsel;
      logic [31:0] hrd;
      logic halt;
      logic run;
   } nku_host_st_t;

   nku_host_st_t s_r;
   nku_host_st_t s_nxt;
   logic taken;
   logic [7:0] rv;
   logic isp;
   logic iso;

   function automatic nku_host_st_t issue(input nku_host_st_t s, input logic we, input logic [15:0] a,
      input logic [7:0] d);
      nku_host_st_t n;
      n = s;
      n.req = 1'b1;
      n.we = we;
      n.aout = a;
      n.dout = d;
      return n;
   endfunction

   assign taken = s_r.req && (s_r.port ? bus.dbg_ready : bus.cpu_ready);
   assign rv = s_r.port ? bus.dbg_rdata : bus.cpu_rdata;
   assign isp = s_r.addr >= nku_pkg::PROG_BASE;
   assign iso = (s_r.addr >= nku_pkg::OPT_BASE) && !isp;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.run = 1'b0;
      s_nxt.wph = 1'b0;
      if (taken)
      begin
         s_nxt.req = 1'b0;
         s_nxt.wt = 1'b1;
      end
      // Read data is valid the cycle after the request is taken
      if (s_r.wt)
      begin
         s_nxt.wt = 1'b0;
         case (s_r.st)
            nku_pkg::H_CHK_ST:
            begin
               if (!(isp ? rv[nku_pkg::ST_PUL_BIT] : rv[nku_pkg::ST_DUL_BIT]))
               begin
                  s_nxt.refd = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.st = nku_pkg::H_IDLE;
               end
               else if (iso)
               begin
                  s_nxt = issue(s_nxt, 1'b0, nku_pkg::REG_CR2, 8'h00);
                  s_nxt.st = nku_pkg::H_CHK_C2;
               end
               else
               begin
                  s_nxt = issue(s_nxt, 1'b1, s_r.addr, s_r.data);
                  s_nxt.st = nku_pkg::H_XFER;
               end
            end
            nku_pkg::H_CHK_C2:
            begin
               if (!rv[nku_pkg::CR2_OPT_BIT])
               begin
                  s_nxt.refd = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.st = nku_pkg::H_IDLE;
               end
               else
               begin
                  s_nxt = issue(s_nxt, 1'b0, nku_pkg::REG_NCR2, 8'h00);
                  s_nxt.st = nku_pkg::H_CHK_N2;
               end
            end
            nku_pkg::H_CHK_N2:
            begin
               if (rv[nku_pkg::CR2_OPT_BIT])
               begin
                  s_nxt.refd = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.st = nku_pkg::H_IDLE;
               end
               else
               begin
                  s_nxt = issue(s_nxt, 1'b1, s_r.addr, s_r.data);
                  s_nxt.st = nku_pkg::H_XFER;
               end
            end
            default:
            begin
               s_nxt.rd = rv;
               s_nxt.refd = s_r.port && bus.dbg_refused;
               s_nxt.done = 1'b1;
               s_nxt.st = nku_pkg::H_IDLE;
            end
         endcase
      end
      // AHB data phase; commands arriving while busy are dropped
      if (s_r.wph)
      begin
         if (s_r.wsel == nku_pkg::HREG_CMD && s_r.st == nku_pkg::H_IDLE)
         begin
            s_nxt.addr = hwdata[15:0];
            s_nxt.data = hwdata[nku_pkg::CMD_DATA_LSB +: 8];
            s_nxt.kind = nku_pkg::nku_kind_t'(hwdata[nku_pkg::CMD_KIND_LSB +: 2]);
            s_nxt.port = hwdata[nku_pkg::CMD_PORT_BIT];
            s_nxt.done = 1'b0;
            s_nxt.refd = 1'b0;
            if (s_nxt.kind == nku_pkg::K_CHECKED)
            begin
               s_nxt = issue(s_nxt, 1'b0, nku_pkg::REG_STAT, 8'h00);
               s_nxt.st = nku_pkg::H_CHK_ST;
            end
            else
            begin
               s_nxt = issue(s_nxt, s_nxt.kind == nku_pkg::K_WRITE, s_nxt.addr, s_nxt.data);
               s_nxt.st = nku_pkg::H_XFER;
            end
         end
         else if (s_r.wsel == nku_pkg::HREG_CTRL)
         begin
            s_nxt.halt = hwdata[0];
            s_nxt.run = hwdata[1];
         end
      end
      if (hsel && htrans[1] && hready)
      begin
         s_nxt.wph = hwrite;
         s_nxt.wsel = haddr[3:2];
         s_nxt.hrd = 32'h0000_0000;
         if (!hwrite && haddr[3:2] == nku_pkg::HREG_STAT)
         begin
            s_nxt.hrd[nku_pkg::HS_BUSY_BIT] = s_r.st != nku_pkg::H_IDLE;
            s_nxt.hrd[nku_pkg::HS_DONE_BIT] = s_r.done;
            s_nxt.hrd[nku_pkg::HS_REF_BIT] = s_r.refd;
            s_nxt.hrd[nku_pkg::HS_IRQ_BIT] = bus.irq;
            s_nxt.hrd[nku_pkg::HS_RD_LSB +: 8] = s_r.rd;
         end
         else if (!hwrite && haddr[3:2] == nku_pkg::HREG_CTRL)
         begin
            s_nxt.hrd[0] = s_r.halt;
            s_nxt.hrd[1] = bus.cpu_halt;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.hrd;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign bus.cpu_req = s_r.req && !s_r.port;
   assign bus.dbg_req = s_r.req && s_r.port;
   assign bus.cpu_we = s_r.we;
   assign bus.dbg_we = s_r.we;
   assign bus.cpu_addr = s_r.aout;
   assign bus.dbg_addr = s_r.aout;
   assign bus.cpu_wdata = s_r.dout;
   assign bus.dbg_wdata = s_r.dout;
   assign bus.dbg_halt = s_r.halt;
   assign bus.dbg_run = s_r.run;
endmodule

// ---- testbench/nku_monitor.sv ----
`timescale 1ns/1ps
module nku_monitor
(
   input logic clk,
   input logic rst,
   input logic cpu_req,
   input logic cpu_we,
   input logic cpu_ready,
   input logic dbg_req,
   input logic dbg_we,
   input logic [15:0] dbg_addr,
   input logic [7:0] dbg_rdata,
   input logic dbg_ready,
   input logic dbg_refused,
   input logic dbg_halt,
   input logic dbg_run,
   input logic cpu_halt,
   input logic irq
);
   logic [9:0] since_wr_r;
   logic tk;
   // Debug loses to the cpu group, so only count it when cpu is quiet
   assign tk = (cpu_req && cpu_ready) || (dbg_req && dbg_ready && !cpu_req);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Cycles since the last accepted store; saturates
   always_ff @(posedge clk or posedge rst)
      if (rst)
         since_wr_r <= 10'h3FF;
      else if ((cpu_req && cpu_ready && cpu_we) || (dbg_req && dbg_ready && !cpu_req && dbg_we))
         since_wr_r <= 10'h000;
      else if (since_wr_r != 10'h3FF)
         since_wr_r <= since_wr_r + 10'h001;
   stall_bound_a: assert property (cpu_req && !cpu_ready |-> ##[1:600] cpu_ready)
      else $error("cpu stall too long");
   stall_cause_a: assert property ((cpu_req && !cpu_ready) || (dbg_req && !dbg_ready && !cpu_req)
      |-> since_wr_r < 10'h259)
      else $error("stall without a store in progress");
   refuse_cause_a: assert property (dbg_refused |-> $past(dbg_req && dbg_ready && !cpu_req))
      else $error("refusal without a debug access");
   refuse_region_a: assert property (dbg_refused
      |-> $past(dbg_addr) inside {[16'h0100:16'h013F], [16'h1000:16'h10FF]})
      else $error("refusal outside protected regions");
   refuse_keep_a: assert property (dbg_refused |-> $stable(dbg_rdata))
      else $error("refused read changed debug data");
   halt_set_a: assert property ($rose(cpu_halt) |-> $past(dbg_halt))
      else $error("cpu halted without request");
   halt_release_a: assert property ($fell(cpu_halt) |-> $past(dbg_run))
      else $error("cpu released without run");
   // Flags and irq move on the edge that takes the clearing access
   irq_clear_a: assert property ($fell(irq) |-> $past(tk))
      else $error("irq dropped without access");
   cover property (dbg_refused);
   cover property (cpu_req && !cpu_ready);
   cover property ($rose(irq));
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic clk, rst, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, st;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_errors, compares, cyc;
   nku_if bus();
   nku_host nku_host_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .bus(bus));
   nku_dev nku_dev_i (.clk(clk), .rst(rst), .bus(bus));
   nku_monitor nku_monitor_i (.clk(clk), .rst(rst), .cpu_req(bus.cpu_req), .cpu_we(bus.cpu_we),
      .cpu_ready(bus.cpu_ready), .dbg_req(bus.dbg_req), .dbg_we(bus.dbg_we), .dbg_addr(bus.dbg_addr),
      .dbg_rdata(bus.dbg_rdata), .dbg_ready(bus.dbg_ready), .dbg_refused(bus.dbg_refused),
      .dbg_halt(bus.dbg_halt), .dbg_run(bus.dbg_run), .cpu_halt(bus.cpu_halt), .irq(bus.irq));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Ceiling well above eight 600-cycle programs plus polling
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         conclude;
      end
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
         n_errors++;
      end
   endtask
   task ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= 32'(a);
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      st = hrdata;
   endtask
   // Polls host status until idle; st then holds the result
   task op(input logic [1:0] k, input logic p, input logic [15:0] a, input logic [7:0] d);
      ahb(1'b1, 4'h0, {5'h00, p, k, d, a});
      do ahb(1'b0, 4'h4, 32'h0000_0000); while (st[0] !== 1'b0);
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      op(nku_pkg::K_WRITE, 1'b0, a, d);
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      op(nku_pkg::K_READ, 1'b0, a, 8'h00);
      chk(st[15:8], e);
   endtask
   task rst_dut;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask
   task s_reset_lock;
      rd(16'h0005, 8'h00);
      wr(16'h0100, 8'h5A);
      rd(16'h0005, 8'h01);
      rd(16'h0100, 8'h00);
      wr(16'h1010, 8'h5A);
      rd(16'h0005, 8'h01);
      ahb(1'b0, 4'h8, 32'h0000_0000);
      chk(st[7:0], 8'h00);
   endtask
   task s_data_keys;
      wr(16'h0004, 8'h11);
      wr(16'h0004, 8'hAE);
      wr(16'h0004, 8'h56);
      rd(16'h0005, 8'h08);
      wr(16'h0100, 8'h5A);
      rd(16'h0100, 8'h5A);
      rd(16'h0005, 8'h0C);
      wr(16'h0100, 8'h00);
      rd(16'h0100, 8'h00);
      wr(16'h0005, 8'h00);
      rd(16'h0005, 8'h04);
      wr(16'h0100, 8'h33);
      rd(16'h0005, 8'h01);
   endtask
   task s_prog_keys;
      op(nku_pkg::K_CHECKED, 1'b0, 16'h1010, 8'h11);
      chk(8'(st[2]), 8'h01);
      wr(16'h0003, 8'h56);
      rd(16'h0003, 8'h00);
      wr(16'h0003, 8'hAE);
      rd(16'h0005, 8'h02);
      wr(16'h1010, 8'hA5);
      rd(16'h1010, 8'hA5);
      rd(16'h0005, 8'h06);
      wr(16'h0005, 8'h00);
      wr(16'h1011, 8'h22);
      rd(16'h0005, 8'h01);
      rd(16'h1011, 8'h00);
   endtask
   task s_prog_lock;
      rst_dut;
      wr(16'h0003, 8'h55);
      wr(16'h0003, 8'h56);
      wr(16'h0003, 8'hAE);
      rd(16'h0005, 8'h00);
      rst_dut;
      wr(16'h0003, 8'h56);
      wr(16'h0003, 8'h00);
      wr(16'h0003, 8'h56);
      wr(16'h0003, 8'hAE);
      rd(16'h0005, 8'h00);
   endtask
   task s_options;
      rst_dut;
      wr(16'h0004, 8'hAE);
      wr(16'h0004, 8'h56);
      wr(16'h0003, 8'h56);
      wr(16'h0003, 8'hAE);
      wr(16'h0001, 8'h80);
      wr(16'h0201, 8'h01);
      rd(16'h0201, 8'h00);
      wr(16'h0002, 8'h7F);
      op(nku_pkg::K_CHECKED, 1'b0, 16'h0201, 8'h01);
      rd(16'h0201, 8'h01);
      wr(16'h1000, 8'h77);
      rd(16'h0005, 8'h0F);
      rd(16'h1000, 8'h00);
      wr(16'h1010, 8'h44);
      rd(16'h1010, 8'h44);
      rd(16'h0005, 8'h0E);
      wr(16'h0101, 8'h3C);
      rd(16'h1010, 8'h44);
      rd(16'h0005, 8'h0A);
      rd(16'h0101, 8'h3C);
      rd(16'h0005, 8'h0E);
      // Control read must wait out the data program, so done is seen after it
      wr(16'h0102, 8'h5A);
      rd(16'h0001, 8'h80);
      rd(16'h0005, 8'h0E);
   endtask
   task s_readout;
      wr(16'h0000, 8'h01);
      wr(16'h0200, 8'hAA);
      rd(16'h0200, 8'hAA);
      chk(8'(st[3]), 8'h01);
      rd(16'h0005, 8'h0E);
      rd(16'h0005, 8'h0A);
      chk(8'(st[3]), 8'h00);
      op(nku_pkg::K_READ, 1'b1, 16'h0100, 8'h00);
      chk(8'(st[2]), 8'h01);
      ahb(1'b1, 4'h8, 32'h0000_0001);
      ahb(1'b1, 4'h8, 32'h0000_0002);
      ahb(1'b0, 4'h8, 32'h0000_0000);
      chk(8'(st[1]), 8'h01);
      op(nku_pkg::K_WRITE, 1'b1, 16'h0200, 8'h00);
      ahb(1'b1, 4'h8, 32'h0000_0002);
      ahb(1'b0, 4'h8, 32'h0000_0000);
      chk(8'(st[1]), 8'h00);
      rd(16'h0101, 8'h00);
      rd(16'h0201, 8'h00);
      // Debug read of status: done from the erase, unlock flags kept
      op(nku_pkg::K_READ, 1'b1, 16'h0005, 8'h00);
      chk(st[15:8], 8'h0E);
      chk(8'(st[2]), 8'h00);
   endtask
   task s_data_lock;
      rst_dut;
      wr(16'h0004, 8'hAE);
      wr(16'h0004, 8'h12);
      wr(16'h0004, 8'hAE);
      wr(16'h0004, 8'h56);
      rd(16'h0005, 8'h00);
   endtask
   initial
   begin
      {rst, hsel, hwrite, htrans, hsize} = {1'b1, 1'b1, 1'b0, 2'h0, 3'h2};
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      n_errors = 0;
      compares = 0;
      cyc = 0;
      rst_dut;
      s_reset_lock;
      s_data_keys;
      s_prog_keys;
      s_prog_lock;
      s_options;
      s_readout;
      s_data_lock;
      conclude;
   end
endmodule
